// [core/aos_pkg.sv]
// shared constants and types for the serial output sequencer and its host
package aos_pkg;

    // word layout: leading zero pad, then result, msb first
    localparam int ZERO_BITS = 6;
    localparam int RESULT_BITS = 10;
    localparam int WORD_BITS = ZERO_BITS + RESULT_BITS;

    // shift-clock edge counts inside one conversion
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_WINDOW_CLOSE = 5'h06;
    localparam logic [4:0] CNT_SPLIT = 5'h08;
    localparam logic [4:0] CNT_LAST_BIT = 5'h10;
    localparam logic [4:0] CNT_FRAME_END = 5'h11;

    // core clock, and the longest pause allowed between two 8-clock groups
    localparam int CLK_PERIOD_NS = 50;
    localparam int SPLIT_GAP_MAX_US = 100;
    localparam int SPLIT_GAP_MAX_CYCLES = (SPLIT_GAP_MAX_US * 1000) / CLK_PERIOD_NS;

    // host timing, in core clock cycles
    localparam logic [3:0] SCLK_HALF_CYCLES = 4'h8;
    localparam logic [3:0] SEL_SETUP_CYCLES = 4'hA;
    localparam logic [11:0] SPLIT_GAP_CYCLES = 12'h028;

    // device operating state
    typedef enum logic [1:0]
    {
        AOS_MODE_OFF = 2'b00,
        AOS_MODE_LATCH = 2'b01,
        AOS_MODE_FRAME = 2'b10,
        AOS_MODE_SPI = 2'b11
    } aos_mode_type;

    // host sequencer state
    typedef enum logic [1:0]
    {
        AOS_HOST_IDLE = 2'b00,
        AOS_HOST_SETUP = 2'b01,
        AOS_HOST_RUN = 2'b10,
        AOS_HOST_GAP = 2'b11
    } aos_host_type;

    // bit idx of the output word: zeros first, then result msb first
    function automatic logic aos_word_bit(input logic [RESULT_BITS-1:0] res,
                                          input logic [4:0] idx);
        logic [4:0] pos;
        pos = 5'(WORD_BITS - 1) - idx;
        if (idx < 5'(ZERO_BITS))
            aos_word_bit = 1'b0;
        else
            aos_word_bit = res[pos[3:0]];
    endfunction

endpackage

// [core/aos_link_if.sv]
`timescale 1ns/100ps
// the four-wire link; sdo is read as driven, sdo_oe only flags when the device drives it
interface aos_link_if;
    logic sel_n;          // active-low select, host driven
    logic sclk;           // shift clock, host driven, idles low
    logic frame_sync_in;  // frame marker, host driven
    logic sdo;            // serial data, device driven
    logic sdo_oe;         // high while the device drives sdo

    modport device
    (
        input sel_n,
        input sclk,
        input frame_sync_in,
        output sdo,
        output sdo_oe
    );

    modport host
    (
        output sel_n,
        output sclk,
        output frame_sync_in,
        input sdo,
        input sdo_oe
    );
endinterface

// [core/aos_device.sv]
`timescale 1ns/100ps
// Contract
// - select high: output released, fully powered down
// - select fall samples frame sync for mode
// - spi mode only if both latches read 1
// - frame host keeps frame sync low across select fall
// - frame mode: frame sync high resets, starts a conversion
// - frame mode: shift word once frame sync drops
// - window opens after fs low, closes at zero six
// - one bit resolved per rising edge, shown later
// - word is six zeros then result
// - result is ten bits wide
// - frame host captures on falling shift edges
// - frame powerdown at falling 17, exit on fs
// - frame output released at rising 17
// - fs in bit 16 gives back-to-back conversion
// - fs mid conversion restarts a fresh conversion
// - select acts at any time, clock independent
// - host may use async start pulse as fs
// - spi host ties fs high, polarity 0, phase 1
// - spi host gives 16 clocks, gap under 100us
// - spi sampling from first rising after select fall
// - spi powerdown falling 16, exit rising 17
// - short spi transfers re-arm via select fall
module aos_device
(
    input wire logic core_clk_i,                               // core clock
    input wire logic reset_i,                                  // sync reset, high
    input wire logic ce_i,                                     // clock enable
    input wire logic [aos_pkg::RESULT_BITS-1:0] sample_data_i, // converter value
    aos_link_if.device link,                                   // pin side
    output logic powerdown_o,                                  // powered down
    output logic spi_mode_o,                                   // spi style chosen
    output logic sample_window_o,                              // sampling open
    output logic [aos_pkg::RESULT_BITS-1:0] result_o           // last result
);

    // every flop of the block in one record
    typedef struct packed
    {
        logic sel_s1;                                // select, first sync stage
        logic sel_s2;                                // select, second sync stage
        logic sel_prev;                              // select, edge history
        logic sclk_s1;                               // shift clock, first stage
        logic sclk_s2;                               // shift clock, second stage
        logic sclk_prev;                             // shift clock, edge history
        logic fs_s1;                                 // frame sync, first stage
        logic fs_s2;                                 // frame sync, second stage
        aos_pkg::aos_mode_type mode;                 // operating mode
        logic latch_a;                               // fs as seen at select fall
        logic running;                               // a frame conversion is live
        logic [4:0] rise_cnt;                        // rising edges in conversion
        logic window;                                // sample window open
        logic powerdown;                             // auto or full powerdown
        logic oe;                                    // data pin driven
        logic sdo;                                   // data pin value
        logic [aos_pkg::RESULT_BITS-1:0] result;     // held conversion result
    } aos_dev_state_type;

    aos_dev_state_type state_r;   // registered state
    aos_dev_state_type state_nxt; // next state

    logic sel_fall;   // select went low
    logic sclk_rise;  // shift clock rising edge
    logic sclk_fall;  // shift clock falling edge

    // edges are taken between the second stage and its history copy only,
    // the first stages never feed logic
    assign sel_fall = state_r.sel_prev & ~state_r.sel_s2;
    assign sclk_rise = ~state_r.sclk_prev & state_r.sclk_s2;
    assign sclk_fall = state_r.sclk_prev & ~state_r.sclk_s2;

    // next-state logic for the whole sequencer
    always_comb
    begin
        state_nxt = state_r;

        // pin synchronisers: the shift clock is sampled, not used as a clock
        state_nxt.sel_s1 = link.sel_n;
        state_nxt.sel_s2 = state_r.sel_s1;
        state_nxt.sel_prev = state_r.sel_s2;
        state_nxt.sclk_s1 = link.sclk;
        state_nxt.sclk_s2 = state_r.sclk_s1;
        state_nxt.sclk_prev = state_r.sclk_s2;
        state_nxt.fs_s1 = link.frame_sync_in;
        state_nxt.fs_s2 = state_r.fs_s1;

        if (state_r.sel_s2)
        begin
            // deselected: released and fully off, whatever the clock does
            state_nxt.mode = aos_pkg::AOS_MODE_OFF;
            state_nxt.oe = 1'b0;
            state_nxt.powerdown = 1'b1;
            state_nxt.running = 1'b0;
            state_nxt.window = 1'b0;
            state_nxt.sdo = 1'b0;
            state_nxt.rise_cnt = aos_pkg::CNT_ZERO;
        end
        else
        begin
            case (state_r.mode)
                aos_pkg::AOS_MODE_OFF:
                begin
                    // select fall: first mode latch, and a reset of the converter
                    if (sel_fall)
                    begin
                        state_nxt.mode = aos_pkg::AOS_MODE_LATCH;
                        state_nxt.latch_a = state_r.fs_s2;
                        state_nxt.rise_cnt = aos_pkg::CNT_ZERO;
                        state_nxt.running = 1'b0;
                    end
                end

                aos_pkg::AOS_MODE_LATCH:
                begin
                    // delayed second latch; a glitch on either gives frame mode,
                    // since the host relies on a clean low here
                    if (state_r.latch_a && state_r.fs_s2)
                    begin
                        state_nxt.mode = aos_pkg::AOS_MODE_SPI;
                        state_nxt.oe = 1'b1;
                    end
                    else
                    begin
                        // frame mode: stays released until the first frame sync
                        state_nxt.mode = aos_pkg::AOS_MODE_FRAME;
                    end
                end

                aos_pkg::AOS_MODE_FRAME:
                begin
                    if (sclk_fall)
                    begin
                        if (state_r.fs_s2)
                        begin
                            // frame sync seen: restart, also mid-word or in bit 16
                            state_nxt.running = 1'b1;
                            state_nxt.rise_cnt = aos_pkg::CNT_ZERO;
                            state_nxt.oe = 1'b1;
                            state_nxt.powerdown = 1'b0;
                            state_nxt.window = 1'b0;
                            state_nxt.sdo = 1'b0;
                        end
                        else if (state_r.running)
                        begin
                            // first falling edge once frame sync is low
                            if (state_r.rise_cnt == aos_pkg::CNT_ONE)
                            begin
                                state_nxt.window = 1'b1;
                            end
                            // falling edge just after the last bit was shown
                            if (state_r.rise_cnt == aos_pkg::CNT_LAST_BIT)
                            begin
                                state_nxt.powerdown = 1'b1;
                            end
                        end
                    end
                    else if (sclk_rise && state_r.running)
                    begin
                        if (state_r.rise_cnt == aos_pkg::CNT_LAST_BIT)
                        begin
                            // seventeenth rising edge: let go of the pin
                            state_nxt.oe = 1'b0;
                            state_nxt.running = 1'b0;
                            state_nxt.sdo = 1'b0;
                        end
                        else
                        begin
                            state_nxt.rise_cnt = state_r.rise_cnt + aos_pkg::CNT_ONE;
                            state_nxt.sdo = aos_pkg::aos_word_bit(state_r.result,
                                                                  state_r.rise_cnt);
                            if (state_nxt.rise_cnt == aos_pkg::CNT_WINDOW_CLOSE)
                            begin
                                // sixth zero leaves: window shuts, value is held
                                state_nxt.window = 1'b0;
                                state_nxt.result = sample_data_i;
                            end
                        end
                    end
                end

                aos_pkg::AOS_MODE_SPI:
                begin
                    if (sclk_rise)
                    begin
                        if ((state_r.rise_cnt == aos_pkg::CNT_ZERO) ||
                            (state_r.rise_cnt == aos_pkg::CNT_LAST_BIT))
                        begin
                            // first or seventeenth rising edge: wake and sample
                            state_nxt.rise_cnt = aos_pkg::CNT_ONE;
                            state_nxt.powerdown = 1'b0;
                            state_nxt.window = 1'b1;
                            state_nxt.sdo = 1'b0;
                        end
                        else
                        begin
                            state_nxt.rise_cnt = state_r.rise_cnt + aos_pkg::CNT_ONE;
                            state_nxt.sdo = aos_pkg::aos_word_bit(state_r.result,
                                                                  state_r.rise_cnt);
                            if (state_nxt.rise_cnt == aos_pkg::CNT_WINDOW_CLOSE)
                            begin
                                // zero six goes out: stop sampling, hold the value
                                state_nxt.window = 1'b0;
                                state_nxt.result = sample_data_i;
                            end
                        end
                    end
                    else if (sclk_fall && (state_r.rise_cnt == aos_pkg::CNT_LAST_BIT))
                    begin
                        // sixteenth falling edge: lsb taken, drop into powerdown
                        state_nxt.powerdown = 1'b1;
                    end
                end

                default:
                begin
                    state_nxt.mode = aos_pkg::AOS_MODE_OFF;
                end
            endcase
        end
    end

    // single state register; the enable freezes everything, syncs included,
    // so a user gating the clock must keep it up through a conversion
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= '0;
            state_r.sel_s1 <= 1'b1;
            state_r.sel_s2 <= 1'b1;
            state_r.sel_prev <= 1'b1;
            state_r.mode <= aos_pkg::AOS_MODE_OFF;
            state_r.powerdown <= 1'b1;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
        end
    end

    // pin and status outputs straight from flops, spi_mode_o decoded from the mode flops
    assign link.sdo = state_r.sdo;
    assign link.sdo_oe = state_r.oe;
    assign powerdown_o = state_r.powerdown;
    assign spi_mode_o = (state_r.mode == aos_pkg::AOS_MODE_SPI);
    assign sample_window_o = state_r.window;
    assign result_o = state_r.result;

endmodule

// [core/aos_host.sv]
`timescale 1ns/100ps
// link master: makes the shift clock by dividing the core clock
module aos_host
(
    input wire logic core_clk_i,                          // core clock
    input wire logic reset_i,                             // sync reset, high
    input wire logic ce_i,                                // clock enable
    input wire logic start_i,                             // one-cycle start request
    input wire logic spi_mode_i,                          // 1: spi style, 0: frame
    input wire logic split_i,                             // spi: two groups of 8
    aos_link_if.host link,                                // pin side
    output logic busy_o,                                  // transfer running
    output logic data_valid_o,                            // one-cycle result strobe
    output logic [aos_pkg::RESULT_BITS-1:0] data_o        // captured result
);

    // all host flops in one record
    typedef struct packed
    {
        aos_pkg::aos_host_type state;                 // sequencer state
        logic spi;                                    // mode of this transfer
        logic split;                                  // pause after 8 clocks
        logic sel_n;                                  // select pin
        logic sclk;                                   // shift clock pin
        logic fs;                                     // frame sync pin
        logic [3:0] half_cnt;                         // divider / setup counter
        logic [4:0] fall_cnt;                         // falling edges made
        logic [11:0] gap_cnt;                         // pause counter
        logic [aos_pkg::WORD_BITS-1:0] shift;         // captured word
        logic [aos_pkg::RESULT_BITS-1:0] data;        // result register
        logic valid;                                  // result strobe
        logic do_s1;                                  // data pin, first stage
        logic do_s2;                                  // data pin, second stage
    } aos_host_state_type;

    aos_host_state_type state_r;   // registered state
    aos_host_state_type state_nxt; // next state

    // host sequencer
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.valid = 1'b0;
        state_nxt.do_s1 = link.sdo;
        state_nxt.do_s2 = state_r.do_s1;

        case (state_r.state)
            aos_pkg::AOS_HOST_IDLE:
            begin
                if (start_i)
                begin
                    // frame sync low across select fall in frame mode, tied high in spi
                    state_nxt.spi = spi_mode_i;
                    state_nxt.split = split_i;
                    state_nxt.sel_n = 1'b0;
                    state_nxt.fs = spi_mode_i;
                    state_nxt.half_cnt = 4'h0;
                    state_nxt.fall_cnt = aos_pkg::CNT_ZERO;
                    state_nxt.state = aos_pkg::AOS_HOST_SETUP;
                end
            end

            aos_pkg::AOS_HOST_SETUP:
            begin
                // hold time after select fall before touching frame sync
                state_nxt.half_cnt = state_r.half_cnt + 4'h1;
                if (state_r.half_cnt == aos_pkg::SEL_SETUP_CYCLES)
                begin
                    state_nxt.fs = 1'b1;
                    state_nxt.half_cnt = 4'h0;
                    state_nxt.state = aos_pkg::AOS_HOST_RUN;
                end
            end

            aos_pkg::AOS_HOST_RUN:
            begin
                state_nxt.half_cnt = state_r.half_cnt + 4'h1;
                if (state_r.half_cnt == aos_pkg::SCLK_HALF_CYCLES - 4'h1)
                begin
                    state_nxt.half_cnt = 4'h0;
                    state_nxt.sclk = ~state_r.sclk;
                    if (!state_r.sclk)
                    begin
                        // rising edge: frame sync drops once it was seen high
                        if (!state_r.spi && (state_r.fall_cnt != aos_pkg::CNT_ZERO))
                        begin
                            state_nxt.fs = 1'b0;
                        end
                    end
                    else
                    begin
                        // falling edge: capture the data pin
                        state_nxt.fall_cnt = state_r.fall_cnt + aos_pkg::CNT_ONE;
                        if (state_r.spi || (state_r.fall_cnt != aos_pkg::CNT_ZERO))
                        begin
                            state_nxt.shift = {state_r.shift[aos_pkg::WORD_BITS-2:0],
                                               state_r.do_s2};
                        end
                        if ((state_r.spi && state_nxt.fall_cnt == aos_pkg::CNT_LAST_BIT) ||
                            (!state_r.spi && state_nxt.fall_cnt == aos_pkg::CNT_FRAME_END))
                        begin
                            // whole word in: release select, re-arms next time
                            state_nxt.sel_n = 1'b1;
                            state_nxt.state = aos_pkg::AOS_HOST_IDLE;
                            state_nxt.valid = 1'b1;
                            state_nxt.data = state_nxt.shift[aos_pkg::RESULT_BITS-1:0];
                        end
                        else if (state_r.spi && state_r.split &&
                                 state_nxt.fall_cnt == aos_pkg::CNT_SPLIT)
                        begin
                            state_nxt.gap_cnt = 12'h000;
                            state_nxt.state = aos_pkg::AOS_HOST_GAP;
                        end
                    end
                end
            end

            aos_pkg::AOS_HOST_GAP:
            begin
                // clock parked low, select kept low, gap far below its limit
                state_nxt.gap_cnt = state_r.gap_cnt + 12'h001;
                if (state_r.gap_cnt == aos_pkg::SPLIT_GAP_CYCLES)
                begin
                    state_nxt.half_cnt = 4'h0;
                    state_nxt.state = aos_pkg::AOS_HOST_RUN;
                end
            end

            default:
            begin
                state_nxt.state = aos_pkg::AOS_HOST_IDLE;
            end
        endcase
    end

    // state register with enable
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= '0;
            state_r.state <= aos_pkg::AOS_HOST_IDLE;
            state_r.sel_n <= 1'b1;
            state_r.fs <= 1'b1;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
        end
    end

    assign link.sel_n = state_r.sel_n;
    assign link.sclk = state_r.sclk;
    assign link.frame_sync_in = state_r.fs;
    assign busy_o = (state_r.state != aos_pkg::AOS_HOST_IDLE);
    assign data_valid_o = state_r.valid;
    assign data_o = state_r.data;

endmodule

// [verification/aos_link_monitor.sv]
`timescale 1ns/100ps
// watches the four link wires where host and device meet
module aos_link_monitor
(
    input wire logic core_clk_i, // core clock
    input wire logic reset_i,    // sync reset, high
    input wire logic sel_n_i,         // select pin, active low
    input wire logic sclk_i,          // shift clock pin
    input wire logic frame_sync_in_i, // frame marker pin
    input wire logic sdo_i,           // serial data pin
    input wire logic sdo_oe_i         // data pin enable
);
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // select falls with the frame marker low or high
    sequence frame_start;
        $fell(sel_n_i) && !frame_sync_in_i;
    endsequence
    sequence spi_start;
        $fell(sel_n_i) && frame_sync_in_i;
    endsequence
    // long margin: the device sees select only through its synchroniser
    a_sel_high_release: assert property (sel_n_i [*6] |-> !sdo_oe_i)
        else $error("data pin driven while deselected");
    a_sclk_idle_low: assert property ($past(sel_n_i) && sel_n_i |-> !sclk_i)
        else $error("shift clock not idle low");
    a_sel_fall_low: assert property ($fell(sel_n_i) |-> !sclk_i)
        else $error("select fell with shift clock high");
    a_frame_fs_hold: assert property (frame_start |=> !frame_sync_in_i [*8])
        else $error("frame marker raised too soon");
    a_spi_fs_tied: assert property (spi_start |-> frame_sync_in_i [*8])
        else $error("frame marker dropped in spi style");
    a_spi_drive_on: assert property (spi_start |-> ##[1:8] sdo_oe_i)
        else $error("data pin not driven after select fall");
    a_frame_wait_fs: assert property (frame_start |-> !sdo_oe_i [*8])
        else $error("data pin driven before frame marker");
    a_sclk_in_sel: assert property ($rose(sclk_i) |-> !sel_n_i)
        else $error("shift clock edge while deselected");
    a_capture_stable: assert property ($fell(sclk_i) && sdo_oe_i |=> $stable(sdo_i))
        else $error("data moved at capture edge");
endmodule

// [verification/adc_serial_output_sequencer_bench.sv]
`timescale 1ns/100ps
// host and device back to back; results compared with the converter value
module adc_serial_output_sequencer_bench;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic spi_mode_i = 1'b0;
    logic split_i = 1'b0;
    logic [aos_pkg::RESULT_BITS-1:0] sample_data_i = 10'h000; // converter stand-in
    logic ce_i = 1'b1; // shared enable of both ends
    logic busy, valid, pd, spi_mode, window, win_seen, mode_seen, pd_seen;
    logic [aos_pkg::RESULT_BITS-1:0] data, result;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    aos_link_if link();
    aos_device i_aos_device(.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .sample_data_i(sample_data_i), .link(link), .powerdown_o(pd),
        .spi_mode_o(spi_mode), .sample_window_o(window), .result_o(result));
    aos_host i_aos_host(.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .start_i(start_i), .spi_mode_i(spi_mode_i), .split_i(split_i), .link(link),
        .busy_o(busy), .data_valid_o(valid), .data_o(data));
    aos_link_monitor i_aos_link_monitor(.core_clk_i(core_clk_i), .reset_i(reset_i),
        .sel_n_i(link.sel_n), .sclk_i(link.sclk), .frame_sync_in_i(link.frame_sync_in),
        .sdo_i(link.sdo), .sdo_oe_i(link.sdo_oe));
    initial
    begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    // remember mode and power state the device showed while its window was open;
    // a start request clears win_seen, so one process owns it
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (start_i === 1'b1)
        begin
            win_seen <= 1'b0;
        end
        else if (window === 1'b1)
        begin
            win_seen <= 1'b1;
            mode_seen <= spi_mode;
            pd_seen <= pd;
        end
        // five transfers need well under 2000 cycles; wide margin
        if (cycles == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one host transfer; the value must come back whole, then the link go idle
    task automatic xfer(input logic spi, input logic split, input logic [9:0] val);
        int n;
        @(posedge core_clk_i);
        sample_data_i <= val;
        spi_mode_i <= spi;
        split_i <= split;
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        n = 0;
        while (valid !== 1'b1 && n < 2000)
        begin
            @(posedge core_clk_i);
            #1 n++;
        end
        check("result strobe", 16'(valid), 16'h0001);
        check("host data", 16'(data), 16'(val));
        check("device result", 16'(result), 16'(val));
        check("window seen", 16'(win_seen), 16'h0001);
        check("mode", 16'(mode_seen), 16'(spi));
        check("awake while sampling", 16'(pd_seen), 16'h0000);
        repeat (8) @(posedge core_clk_i);
        #1 check("pin released", 16'(link.sdo_oe), 16'h0000);
        check("powered down", 16'(pd), 16'h0001);
        check("host idle", 16'(busy), 16'h0000);
    endtask
    // with the enable low a start request is lost and nothing moves
    task automatic test_freeze();
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        spi_mode_i <= 1'b0;
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        ce_i <= 1'b1;
        #1 check("frozen busy", 16'(busy), 16'h0000);
        repeat (20) @(posedge core_clk_i);
        #1 check("frozen pin", 16'(link.sdo_oe), 16'h0000);
        check("frozen powerdown", 16'(pd), 16'h0001);
    endtask
    task automatic test_frame();
        xfer(1'b0, 1'b0, 10'h2A5);
    endtask
    task automatic test_spi();
        xfer(1'b1, 1'b0, 10'h3FF);
    endtask
    task automatic test_split();
        xfer(1'b1, 1'b1, 10'h001);
    endtask
    // alternating modes, frame then spi, with only the settle cycles of xfer between transfers
    task automatic test_mode_swap();
        xfer(1'b0, 1'b0, 10'h200);
        xfer(1'b1, 1'b0, 10'h155);
    endtask
    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        test_frame();
        test_spi();
        test_split();
        test_mode_swap();
        test_freeze();
        finish_test();
    end
endmodule
